/* File: hw/ccs_top.sv */
// Command register executor and auto-calibration sequencer
`timescale 1ns/10ps
`default_nettype none
module ccs_top #(
  parameter int NV_CYCLES = ccs_pkg::NV_CYC
) (
  // Clocks and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  input  wire logic                               link_clk,
  // Register access from the serial link
  input  wire logic                               link_req,
  input  wire ccs_pkg::ccs_req_type               link_cmd,
  output logic                                    link_busy,
  output logic                                    link_rvalid,
  output logic [15:0]                             link_rdata,
  // Calibration pin and motion events
  input  wire logic                               calibrate_pin_n,
  input  wire logic                               half_rev,
  input  wire logic                               dir_rev,
  input  wire logic                               tune_valid,
  input  wire ccs_pkg::ccs_word_type              tune,
  // Position and interpolator
  input  wire ccs_pkg::ccs_pos_type               abs_pos,
  output ccs_pkg::ccs_pos_type                    preset_offset,
  output logic                                    ipo_run,
  output logic                                    cal_active,
  output logic                                    cal_tune_en,
  output logic                                    status_clear,
  output logic                                    lin_cal_reset,
  output logic                                    linearity_cal_enable,
  output logic [ccs_pkg::NPAR-1:0][15:0]          param_q,
  // Nonvolatile memory controller
  output logic                                    nv_req,
  output ccs_pkg::ccs_nvop_type                   nv_op,
  input  wire logic                               nv_done,
  input  wire logic                               nv_load_valid,
  input  wire ccs_pkg::ccs_word_type              nv_load
);
  ccs_pkg::ccs_state_type st_r;
  ccs_pkg::ccs_req_type   lk_hold_r;
  logic [15:0]            rd_r;
  logic [15:0]            rd_nxt;
  logic                   req_tgl_r, ack_tgl_r;
  logic [2:0]             req_s_r, ack_s_r;
  logic [7:0]             cmd_r, key_r;
  logic [1:0]             ctrl_r;
  logic [1:0]             hrev_r;
  logic [2:0]             pin_s_r;
  logic                   pin_pend_r, copy_go_r;
  logic [31:0]            nv_tmr_r;
  logic                   acc_go, cmd_wr, prot, allowed, pin_fall, pin_rise;
  logic                   par_hit, cal_stop;
  logic [4:0]             par_ix;
  logic [7:0]             wcode;

  // Link domain: hold the request until the system side acknowledges it
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_hold_r <= '0;
      req_tgl_r <= 1'b0;
      link_busy <= 1'b0;
    end else if (link_req && !link_busy) begin
      lk_hold_r <= link_cmd;
      req_tgl_r <= ~req_tgl_r;
      link_busy <= 1'b1;
    end else if (ack_s_r[2] ^ ack_s_r[1]) begin
      link_busy <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s_r     <= 3'h0;
      link_rvalid <= 1'b0;
      link_rdata  <= 16'h0000;
    end else begin
      ack_s_r     <= {ack_s_r[1:0], ack_tgl_r};
      link_rvalid <= ack_s_r[2] ^ ack_s_r[1];
      // rd_r is stable for a whole handshake, so it may be sampled here
      if (ack_s_r[2] ^ ack_s_r[1]) begin
        link_rdata <= rd_r;
      end
    end
  end

  // System domain: request toggle and pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_s_r <= 3'h0;
      pin_s_r <= 3'h7;
    end else begin
      req_s_r <= {req_s_r[1:0], req_tgl_r};
      pin_s_r <= {pin_s_r[1:0], calibrate_pin_n};
    end
  end

  assign acc_go   = req_s_r[2] ^ req_s_r[1];
  assign pin_fall = pin_s_r[2] & ~pin_s_r[1];
  assign pin_rise = ~pin_s_r[2] & pin_s_r[1];
  assign cmd_wr   = acc_go && lk_hold_r.we && (lk_hold_r.addr == ccs_pkg::ADDR_COMMAND);
  assign wcode    = lk_hold_r.wdata[7:0];
  assign prot     = (wcode == ccs_pkg::CMD_STOP) || (wcode >= ccs_pkg::CMD_COPY);
  assign allowed  = (!prot || key_r == ccs_pkg::UNLOCK_KEY)
                  && (wcode < ccs_pkg::CMD_STCFG || wcode > ccs_pkg::CMD_STSEL
                      || ctrl_r[ccs_pkg::CTRL_NV_WE]);
  assign cal_stop = (cmd_wr && wcode == ccs_pkg::CMD_IDLE) || pin_rise;

  always_comb begin
    par_hit = 1'b1;
    par_ix  = 5'h00;
    if (lk_hold_r.addr == ccs_pkg::ADDR_LIN_AMP) begin
      par_ix = ccs_pkg::IX_LAMP;
    end else if (lk_hold_r.addr == ccs_pkg::ADDR_LIN_PH) begin
      par_ix = ccs_pkg::IX_LPH;
    end else if (lk_hold_r.addr >= ccs_pkg::ADDR_PAR_BASE
                 && lk_hold_r.addr <= ccs_pkg::ADDR_PAR_BASE + 16'(ccs_pkg::IX_TALRM)) begin
      par_ix = 5'(lk_hold_r.addr - ccs_pkg::ADDR_PAR_BASE);
    end else begin
      par_hit = 1'b0;
    end
  end

  // Range shaping on every write
  function automatic logic [15:0] ccs_fmt(input logic [4:0] ix, input logic [15:0] d);
    if (ix == ccs_pkg::IX_AGAIN) begin
      return (d > ccs_pkg::AGAIN_MAX) ? ccs_pkg::AGAIN_MAX : d;
    end else if (ix == ccs_pkg::IX_ASOFS || ix == ccs_pkg::IX_ACOFS) begin
      return {{10{d[5]}}, d[5:0]};
    end else if (ix == ccs_pkg::IX_DGAIN) begin
      return {4'h0, d[11:0]};
    end else if ((ix >= ccs_pkg::IX_BAL && ix <= ccs_pkg::IX_PH)
                 || (ix >= ccs_pkg::IX_SBASE && ix <= ccs_pkg::IX_PBASE)) begin
      return {{4{d[11]}}, d[11:0]};
    end else if (ix == ccs_pkg::IX_WEAK) begin
      return (d > ccs_pkg::WEAK_MAX) ? ccs_pkg::WEAK_MAX : d;
    end else if ((ix >= ccs_pkg::IX_OFSTH && ix <= ccs_pkg::IX_APHTH)
                 || (ix >= ccs_pkg::IX_OLIM && ix <= ccs_pkg::IX_PLIM)) begin
      return {5'h00, d[10:0]};
    end else begin
      return d;
    end
  endfunction : ccs_fmt

  always_comb begin
    rd_nxt = 16'h0000;
    if (par_hit) begin
      rd_nxt = param_q[par_ix];
    end else if (lk_hold_r.addr == ccs_pkg::ADDR_COMMAND) begin
      rd_nxt = {8'h00, cmd_r};
    end else if (lk_hold_r.addr == ccs_pkg::ADDR_KEY) begin
      rd_nxt = {8'h00, key_r};
    end else if (lk_hold_r.addr == ccs_pkg::ADDR_CTRL) begin
      rd_nxt = {14'h0000, ctrl_r};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_r      <= 16'h0000;
      ack_tgl_r <= 1'b0;
    end else if (acc_go) begin
      rd_r      <= rd_nxt;
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_r  <= 8'h00;
      ctrl_r <= 2'h0;
    end else if (acc_go && lk_hold_r.we) begin
      if (lk_hold_r.addr == ccs_pkg::ADDR_KEY) begin
        key_r <= lk_hold_r.wdata[7:0];
      end
      if (lk_hold_r.addr == ccs_pkg::ADDR_CTRL) begin
        ctrl_r <= lk_hold_r.wdata[1:0];
      end
    end
  end
  assign linearity_cal_enable = ctrl_r[ccs_pkg::CTRL_LIN_EN];

  // Parameter file: copy beats load beats host write beats tuning
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      param_q <= ccs_pkg::RST_VAL;
    end else if (copy_go_r) begin
      param_q[ccs_pkg::IX_SBASE] <= param_q[ccs_pkg::IX_SOFS];
      param_q[ccs_pkg::IX_CBASE] <= param_q[ccs_pkg::IX_COFS];
      param_q[ccs_pkg::IX_BBASE] <= param_q[ccs_pkg::IX_BAL];
      param_q[ccs_pkg::IX_PBASE] <= param_q[ccs_pkg::IX_PH];
    end else if (nv_load_valid && st_r == ccs_pkg::ST_NV && nv_op == ccs_pkg::NV_LOAD
                 && nv_load.idx <= ccs_pkg::IX_LPH) begin
      param_q[nv_load.idx] <= ccs_fmt(nv_load.idx, nv_load.data);
    end else if (acc_go && lk_hold_r.we && par_hit) begin
      param_q[par_ix] <= ccs_fmt(par_ix, lk_hold_r.wdata);
    end else if (tune_valid && tune.idx <= ccs_pkg::IX_PH
                 && ((st_r == ccs_pkg::ST_CALIB && cal_tune_en)
                     || (st_r == ccs_pkg::ST_IDLE && ipo_run))) begin
      param_q[tune.idx] <= ccs_fmt(tune.idx, tune.data);
    end
  end

  // Both linearity words zero after a write clears the linearity result
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lin_cal_reset <= 1'b0;
    end else begin
      lin_cal_reset <= acc_go && lk_hold_r.we && lk_hold_r.wdata == 16'h0000
        && ((par_ix == ccs_pkg::IX_LAMP && param_q[ccs_pkg::IX_LPH] == 16'h0000)
            || (par_ix == ccs_pkg::IX_LPH && param_q[ccs_pkg::IX_LAMP] == 16'h0000))
        && par_hit;
    end
  end

  // Revolution gate: three half turns with no reversal
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrev_r      <= 2'h0;
      cal_tune_en <= 1'b0;
    end else if (st_r != ccs_pkg::ST_CALIB || dir_rev) begin
      hrev_r      <= 2'h0;
      cal_tune_en <= 1'b0;
    end else begin
      if (half_rev && hrev_r != ccs_pkg::HALF_REVS_MIN) begin
        hrev_r <= hrev_r + 2'h1;
      end
      cal_tune_en <= (hrev_r == ccs_pkg::HALF_REVS_MIN);
    end
  end

  // A pin press waits here if the sequencer is busy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_pend_r <= 1'b0;
    end else if (pin_fall) begin
      pin_pend_r <= 1'b1;
    end else if (pin_rise || st_r == ccs_pkg::ST_CALIB) begin
      pin_pend_r <= 1'b0;
    end
  end

  // Command sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= ccs_pkg::ST_IDLE;
      cmd_r         <= ccs_pkg::CMD_IDLE;
      nv_req        <= 1'b0;
      nv_op         <= ccs_pkg::NV_NONE;
      nv_tmr_r      <= 32'h0000_0000;
      ipo_run       <= 1'b1;
      copy_go_r     <= 1'b0;
      status_clear  <= 1'b0;
      preset_offset <= '0;
      cal_active    <= 1'b0;
    end else begin
      copy_go_r    <= 1'b0;
      status_clear <= 1'b0;
      unique case (st_r)
        ccs_pkg::ST_IDLE: begin
          if (pin_pend_r) begin
            st_r       <= ccs_pkg::ST_CALIB;
            cmd_r      <= ccs_pkg::CMD_CALIB;
            cal_active <= 1'b1;
          end else if (cmd_wr && allowed) begin
            unique case (wcode)
              ccs_pkg::CMD_STOP:  ipo_run <= 1'b0;
              ccs_pkg::CMD_START: ipo_run <= 1'b1;
              ccs_pkg::CMD_CLRST: status_clear <= 1'b1;
              ccs_pkg::CMD_COPY:  copy_go_r <= 1'b1;
              ccs_pkg::CMD_PRESET: begin
                preset_offset.turns <= ~abs_pos.turns + 24'h000001;
                preset_offset.angle <= ~abs_pos.angle + 24'h000001;
                nv_op               <= ccs_pkg::NV_PRESET;
              end
              ccs_pkg::CMD_LOAD:  nv_op <= ccs_pkg::NV_LOAD;
              ccs_pkg::CMD_STCFG: nv_op <= ccs_pkg::NV_CFG;
              ccs_pkg::CMD_STALL: nv_op <= ccs_pkg::NV_ALLCOR;
              ccs_pkg::CMD_STSEL: nv_op <= ccs_pkg::NV_SELCOR;
              ccs_pkg::CMD_CALIB: begin
                st_r       <= ccs_pkg::ST_CALIB;
                cmd_r      <= ccs_pkg::CMD_CALIB;
                cal_active <= 1'b1;
              end
              default: ;
            endcase
            if (wcode == ccs_pkg::CMD_PRESET || wcode == ccs_pkg::CMD_LOAD
                || (wcode >= ccs_pkg::CMD_STCFG && wcode <= ccs_pkg::CMD_STSEL)) begin
              st_r     <= ccs_pkg::ST_NV;
              cmd_r    <= wcode;
              nv_req   <= 1'b1;
              nv_tmr_r <= 32'(NV_CYCLES - 1);
            end
          end
        end
        ccs_pkg::ST_NV: begin
          // Abort is not honoured here: a half-written store is worse
          if (nv_done || nv_tmr_r == 32'h0000_0000) begin
            st_r   <= ccs_pkg::ST_IDLE;
            cmd_r  <= ccs_pkg::CMD_IDLE;
            nv_req <= 1'b0;
            nv_op  <= ccs_pkg::NV_NONE;
            if (nv_op == ccs_pkg::NV_LOAD) begin
              ipo_run <= 1'b1;
            end
          end else begin
            nv_tmr_r <= nv_tmr_r - 32'h0000_0001;
          end
        end
        ccs_pkg::ST_CALIB: begin
          // Leaving this state on the first stop makes the wrap-up unique
          if (cal_stop) begin
            st_r       <= ccs_pkg::ST_CALEND;
            copy_go_r  <= 1'b1;
            cal_active <= 1'b0;
          end
        end
        ccs_pkg::ST_CALEND: begin
          st_r     <= ccs_pkg::ST_NV;
          nv_req   <= 1'b1;
          nv_op    <= ccs_pkg::NV_CALIB;
          nv_tmr_r <= 32'(NV_CYCLES - 1);
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seq_cal_stop;
    st_r == ccs_pkg::ST_CALIB && cal_stop;
  endsequence
  sequence seq_wrapup;
    copy_go_r && st_r == ccs_pkg::ST_CALEND ##1 nv_req && nv_op == ccs_pkg::NV_CALIB;
  endsequence
  sequence seq_idle_cmd(logic [7:0] c);
    st_r == ccs_pkg::ST_IDLE && !pin_pend_r && cmd_wr && allowed && wcode == c;
  endsequence

  AST_PRESET_NEG: assert property (seq_idle_cmd(ccs_pkg::CMD_PRESET) |=>
      preset_offset.turns + $past(abs_pos.turns) == 24'h000000
      && preset_offset.angle + $past(abs_pos.angle) == 24'h000000)
    else $error("preset offset is not the negated position");
  AST_PRESET_STORE: assert property (seq_idle_cmd(ccs_pkg::CMD_PRESET) |=>
      nv_req && nv_op == ccs_pkg::NV_PRESET && cmd_r == ccs_pkg::CMD_PRESET)
    else $error("preset not committed to nonvolatile memory");
  AST_CLEAR: assert property (seq_idle_cmd(ccs_pkg::CMD_CLRST) |=>
      status_clear ##1 !status_clear)
    else $error("status clear is not a single pulse");
  AST_COPY: assert property (copy_go_r |=>
      param_q[ccs_pkg::IX_SBASE] == $past(param_q[ccs_pkg::IX_SOFS])
      && param_q[ccs_pkg::IX_PBASE] == $past(param_q[ccs_pkg::IX_PH]))
    else $error("base registers do not match corrections");
  AST_COPY_NOSTORE: assert property (seq_idle_cmd(ccs_pkg::CMD_COPY) |=>
      !nv_req [*2])
    else $error("copy command started a store");
  AST_LOAD_RUN: assert property (st_r == ccs_pkg::ST_NV && nv_op == ccs_pkg::NV_LOAD
      && nv_done |=> ipo_run && cmd_r == ccs_pkg::CMD_IDLE)
    else $error("load did not start the interpolator");
  AST_STORE_TIME: assert property ($rose(nv_req) |-> nv_tmr_r == 32'(NV_CYCLES - 1))
    else $error("store timer not loaded with one second");
  AST_CAL_END: assert property (seq_cal_stop |=> seq_wrapup)
    else $error("calibration end did not copy then store");
  AST_TUNE_GATE: assert property (st_r == ccs_pkg::ST_CALIB && !cal_tune_en && tune_valid
      && !acc_go && !copy_go_r |=> $stable(param_q))
    else $error("corrections changed before enough revolutions");
  AST_BUSY_CODE: assert property (nv_req |-> cmd_r != ccs_pkg::CMD_IDLE)
    else $error("command register idle during a store");
  AST_KEY: assert property (st_r == ccs_pkg::ST_IDLE && !pin_pend_r && cmd_wr
      && wcode == ccs_pkg::CMD_CALIB && key_r != ccs_pkg::UNLOCK_KEY
      |=> st_r == ccs_pkg::ST_IDLE && !nv_req)
    else $error("locked protected command executed");
endmodule : ccs_top
`default_nettype wire

/* File: include/ccs_pkg.sv */
// Constants and types for the calibration command sequencer
package ccs_pkg;
  localparam int NPAR = 23;
  // Parameter register indices
  localparam logic [4:0] IX_AGAIN = 5'h00;
  localparam logic [4:0] IX_ASOFS = 5'h01;
  localparam logic [4:0] IX_ACOFS = 5'h02;
  localparam logic [4:0] IX_DGAIN = 5'h03;
  localparam logic [4:0] IX_BAL   = 5'h04;
  localparam logic [4:0] IX_SOFS  = 5'h05;
  localparam logic [4:0] IX_COFS  = 5'h06;
  localparam logic [4:0] IX_PH    = 5'h07;
  localparam logic [4:0] IX_WEAK  = 5'h08;
  localparam logic [4:0] IX_OFSTH = 5'h09;
  localparam logic [4:0] IX_APHTH = 5'h0C;
  localparam logic [4:0] IX_SBASE = 5'h0D;
  localparam logic [4:0] IX_CBASE = 5'h0E;
  localparam logic [4:0] IX_BBASE = 5'h0F;
  localparam logic [4:0] IX_PBASE = 5'h10;
  localparam logic [4:0] IX_OLIM  = 5'h11;
  localparam logic [4:0] IX_PLIM  = 5'h13;
  localparam logic [4:0] IX_TALRM = 5'h14;
  localparam logic [4:0] IX_LAMP  = 5'h15;
  localparam logic [4:0] IX_LPH   = 5'h16;
  // Register addresses
  localparam logic [15:0] ADDR_PAR_BASE = 16'h0600;
  localparam logic [15:0] ADDR_LIN_AMP  = 16'h070C;
  localparam logic [15:0] ADDR_LIN_PH   = 16'h070E;
  localparam logic [15:0] ADDR_COMMAND  = 16'h4000;
  localparam logic [15:0] ADDR_KEY      = 16'h4001;
  localparam logic [15:0] ADDR_CTRL     = 16'h4002;
  localparam int          CTRL_LIN_EN   = 0;
  localparam int          CTRL_NV_WE    = 1;
  // Command codes
  localparam logic [7:0] CMD_IDLE   = 8'h00;
  localparam logic [7:0] CMD_STOP   = 8'h02;
  localparam logic [7:0] CMD_START  = 8'h04;
  localparam logic [7:0] CMD_PRESET = 8'h05;
  localparam logic [7:0] CMD_CLRST  = 8'h06;
  localparam logic [7:0] CMD_COPY   = 8'h0A;
  localparam logic [7:0] CMD_LOAD   = 8'h0B;
  localparam logic [7:0] CMD_STCFG  = 8'h0C;
  localparam logic [7:0] CMD_STALL  = 8'h0D;
  localparam logic [7:0] CMD_STSEL  = 8'h0E;
  localparam logic [7:0] CMD_CALIB  = 8'h10;
  localparam logic [7:0] UNLOCK_KEY = 8'hB4;
  // Ranges and reset values
  localparam logic [15:0] AGAIN_MAX = 16'h0017;
  localparam logic [15:0] WEAK_MAX  = 16'h0B40;
  localparam logic [1:0]  HALF_REVS_MIN = 2'h3;
  localparam logic [NPAR-1:0][15:0] RST_VAL = {
    16'h0000, 16'h0000, 16'h04B0, 16'h07FF, 16'h07FF, 16'h07FF,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h00C8,
    16'h00C8, 16'h00C8, 16'h04B0, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0005};
  // Nonvolatile store time
  localparam int NV_TIME_MS = 1000;
  localparam int CLK_HZ     = 125000000;
  localparam int NV_CYC     = CLK_HZ / 1000 * NV_TIME_MS;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ccs_req_type;

  typedef struct packed {
    logic [23:0] turns;
    logic [23:0] angle;
  } ccs_pos_type;

  typedef struct packed {
    logic [4:0]  idx;
    logic [15:0] data;
  } ccs_word_type;

  typedef enum logic [2:0] {
    NV_NONE = 3'b000, NV_CFG = 3'b001, NV_ALLCOR = 3'b010, NV_SELCOR = 3'b011,
    NV_PRESET = 3'b100, NV_CALIB = 3'b101, NV_LOAD = 3'b110
  } ccs_nvop_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_NV = 2'b01, ST_CALIB = 2'b10, ST_CALEND = 2'b11
  } ccs_state_type;
endpackage : ccs_pkg

/* File: tb/ccs_host_model.sv */
// Serial link host model for the command sequencer
`timescale 1ns/10ps
`default_nettype none
module ccs_host_model (
  // Link answer
  input  wire logic            link_clk,
  input  wire logic            link_rvalid,
  input  wire logic [15:0]     link_rdata,
  // Link request
  output logic                 link_req,
  output ccs_pkg::ccs_req_type link_cmd
);
  logic [15:0] q;
  initial begin
    link_req = 1'b0;
    link_cmd = '0;
  end
  task xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    int n;
    @(posedge link_clk);
    #1 link_req = 1'b1;
    link_cmd = {w, a, d};
    @(posedge link_clk);
    #1 link_req = 1'b0;
    // Scramble released fields so a stale value cannot pass
    link_cmd = ~link_cmd;
    // Look just after each edge so the answer pulse is seen while it stands
    for (n = 0; n < 40; n++) begin
      @(posedge link_clk);
      #1;
      if (link_rvalid === 1'b1) break;
    end
    q = link_rdata;
  endtask : xfer
  task wait_idle;
    int n;
    q = 16'hFFFF;
    for (n = 0; n < 300 && q[7:0] !== 8'h00; n++) xfer(1'b0, ccs_pkg::ADDR_COMMAND, 16'h0000);
  endtask : wait_idle
  task command(input logic [7:0] c);
    xfer(1'b1, ccs_pkg::ADDR_COMMAND, {8'h00, c});
    wait_idle();
  endtask : command
endmodule : ccs_host_model
`default_nettype wire

/* File: tb/ccs_top_test.sv */
// Self-checking bench for the calibration command sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module ccs_top_test;
  logic clk_sys = 1'b0, link_clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, half_rev = 1'b0;
  logic tune_valid = 1'b0, nv_done = 1'b0, sc_seen = 1'b0, lr_seen = 1'b0, dir_rev = 1'b0;
  logic link_req, link_busy, link_rvalid, ipo_run, cal_active, cal_tune_en;
  logic status_clear, lin_cal_reset, lin_en, nv_req;
  logic [15:0] link_rdata;
  logic [5:0] nvc = 6'h00;
  logic [ccs_pkg::NPAR-1:0][15:0] param_q;
  ccs_pkg::ccs_req_type link_cmd;
  ccs_pkg::ccs_word_type tune = '0;
  ccs_pkg::ccs_pos_type abs_pos = '0, preset_offset;
  ccs_pkg::ccs_nvop_type nv_op, ops[$];
  int err_count = 0, samples_checked = 0, cyc = 0, i;
  logic [7:0] codes[4] = '{8'h0C, 8'h0D, 8'h0E, 8'h0B};
  ccs_pkg::ccs_nvop_type exp_op[4] = '{ccs_pkg::NV_CFG, ccs_pkg::NV_ALLCOR, ccs_pkg::NV_SELCOR, ccs_pkg::NV_LOAD};
  ccs_top #(.NV_CYCLES(50)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .link_clk(link_clk),
    .link_req(link_req), .link_cmd(link_cmd), .link_busy(link_busy), .link_rvalid(link_rvalid),
    .link_rdata(link_rdata), .calibrate_pin_n(pin_n), .half_rev(half_rev), .dir_rev(dir_rev),
    .tune_valid(tune_valid), .tune(tune), .abs_pos(abs_pos), .preset_offset(preset_offset),
    .ipo_run(ipo_run), .cal_active(cal_active), .cal_tune_en(cal_tune_en),
    .status_clear(status_clear), .lin_cal_reset(lin_cal_reset), .linearity_cal_enable(lin_en),
    .param_q(param_q), .nv_req(nv_req), .nv_op(nv_op), .nv_done(nv_done),
    .nv_load_valid(1'b0), .nv_load('0));
  ccs_host_model host (.link_clk(link_clk), .link_rvalid(link_rvalid), .link_rdata(link_rdata),
    .link_req(link_req), .link_cmd(link_cmd));
  initial forever #4 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // Memory controller answers each store after 45 cycles, inside the 50-cycle timeout
  always @(posedge clk_sys) begin
    cyc++;
    nvc <= nv_req ? nvc + 6'h01 : 6'h00;
    nv_done <= nv_req && nvc == 6'h2D;
    if (nv_req === 1'b1 && nvc == 6'h00) ops.push_back(nv_op);
    if (status_clear === 1'b1) sc_seen <= 1'b1;
    if (lin_cal_reset === 1'b1) lr_seen <= 1'b1;
    if (cyc == 90000) begin
      err_count++;
      end_sim();
    end
  end
  task rd(input logic [15:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000);
    `CHK(host.q, e)
    `CHK(link_busy, 1'b0)
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task t_regs;
    rd(16'h0600, 16'h0005);
    rd(16'h0603, 16'h0064);
    rd(16'h0608, 16'h04B0);
    rd(16'h0609, 16'h00C8);
    rd(16'h060C, 16'h0064);
    rd(16'h0611, 16'h07FF);
    rd(16'h060D, 16'h0000);
    rd(16'h0614, 16'h04B0);
    host.xfer(1'b1, 16'h0608, 16'h0FFF);
    rd(16'h0608, 16'h0B40);
    host.xfer(1'b1, 16'h0601, 16'h0020);
    rd(16'h0601, 16'hFFE0);
    host.xfer(1'b1, 16'h0605, 16'h0F00);
    rd(16'h0605, 16'hFF00);
  endtask : t_regs
  task t_simple;
    host.command(ccs_pkg::CMD_CLRST);
    `CHK(sc_seen, 1'b1)
    `CHK(host.q[7:0], 8'h00)
    host.xfer(1'b1, ccs_pkg::ADDR_LIN_AMP, 16'h0000);
    host.xfer(1'b1, ccs_pkg::ADDR_LIN_PH, 16'h0000);
    `CHK(lr_seen, 1'b1)
  endtask : t_simple
  task t_copy;
    host.xfer(1'b1, 16'h0605, 16'h0123);
    host.command(ccs_pkg::CMD_COPY);
    rd(16'h060D, 16'h0000);
    host.xfer(1'b1, ccs_pkg::ADDR_KEY, 16'h00B4);
    host.command(ccs_pkg::CMD_COPY);
    rd(16'h060D, 16'h0123);
    `CHK(ops.size(), 0)
  endtask : t_copy
  task t_preset;
    abs_pos = {24'h000010, 24'h000100};
    host.xfer(1'b1, ccs_pkg::ADDR_COMMAND, 16'h0005);
    host.xfer(1'b0, ccs_pkg::ADDR_COMMAND, 16'h0000);
    `CHK(host.q[7:0], ccs_pkg::CMD_PRESET)
    host.wait_idle();
    `CHK(preset_offset, {24'hFFFFF0, 24'hFFFF00})
    `CHK(ops.pop_front(), ccs_pkg::NV_PRESET)
  endtask : t_preset
  task tune_w(input logic [15:0] d);
    tick(1);
    tune_valid = 1'b1;
    tune = {ccs_pkg::IX_SOFS, d};
    tick(1);
    tune_valid = 1'b0;
    tick(3);
  endtask : tune_w
  task t_cal;
    host.xfer(1'b1, ccs_pkg::ADDR_KEY, 16'h0000);
    host.xfer(1'b1, ccs_pkg::ADDR_COMMAND, 16'h0010);
    `CHK(cal_active, 1'b0)
    host.xfer(1'b1, ccs_pkg::ADDR_KEY, 16'h00B4);
    host.xfer(1'b1, ccs_pkg::ADDR_CTRL, 16'h0003);
    `CHK(lin_en, 1'b1)
    host.xfer(1'b1, ccs_pkg::ADDR_COMMAND, 16'h0010);
    `CHK(cal_active, 1'b1)
    // Half turns come unevenly spaced: a reversal before the second, a tuning word before the fourth
    for (i = 0; i < 4; i++) begin
      if (i == 1) begin
        tick(1);
        dir_rev = 1'b1;
        tick(1);
        dir_rev = 1'b0;
      end
      if (i == 3) tune_w(16'h0077);
      tick(1);
      half_rev = 1'b1;
      tick(1);
      half_rev = 1'b0;
    end
    `CHK(param_q[ccs_pkg::IX_SOFS], 16'h0123)
    tick(2);
    `CHK(cal_tune_en, 1'b1)
    tune_w(16'h0055);
    `CHK(param_q[ccs_pkg::IX_SOFS], 16'h0055)
    host.command(ccs_pkg::CMD_IDLE);
    `CHK(param_q[ccs_pkg::IX_SBASE], 16'h0055)
    `CHK(ops.pop_front(), ccs_pkg::NV_CALIB)
    host.command(ccs_pkg::CMD_COPY);
    host.command(ccs_pkg::CMD_STOP);
    `CHK(ipo_run, 1'b0)
    host.command(ccs_pkg::CMD_START);
    `CHK(ipo_run, 1'b1)
    host.command(ccs_pkg::CMD_STOP);
    for (i = 0; i < 4; i++) begin
      host.command(codes[i]);
      `CHK(ops.pop_front(), exp_op[i])
    end
    `CHK(ipo_run, 1'b1)
  endtask : t_cal
  task t_pin;
    pin_n = 1'b0;
    tick(10);
    `CHK(cal_active, 1'b1)
    host.xfer(1'b1, ccs_pkg::ADDR_COMMAND, 16'h0010);
    pin_n = 1'b1;
    host.command(ccs_pkg::CMD_IDLE);
    `CHK(ops.size(), 1)
    `CHK(ops.pop_front(), ccs_pkg::NV_CALIB)
    `CHK(cal_active, 1'b0)
  endtask : t_pin
  task end_sim;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge link_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge link_clk);
    t_regs();
    t_simple();
    t_copy();
    t_preset();
    t_cal();
    t_pin();
    end_sim();
  end
endmodule : ccs_top_test
`default_nettype wire
